// file: logic/lcdcd_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Direction select high maps segment one to column zero
// - Frame sync high presets line counter from start
// - Line latch rise latches row, advances line counter
// - Phase clocks pace execution; scanning ignores them
// - Polarity and bit choose one of four levels
// - Reset clears display on and start line
// - After reset only instructions change those two
// - Deselected chip ignores strobe, never drives bus
// - Reset and direction select ignore chip selects
// - Data/instruction and read/write pick the operation
// - Data write captured at strobe fall, stored later
// - Data read drives output register, reloads at fall
// - Output register survives address changes: dummy read
// - Busy shows on bit seven, blocks other accesses
// - Off state blanks segments, ram unchanged
// - Status bit five reports the display state
// - Start line instruction stores six-bit scroll line
// - Page register plus column counter form address
// - Column counter increments after data access, wraps
// - Stored one lights the dot
// - Status bit four shows reset in progress
// - On/off instruction takes data bit zero
module lcdcd_core #(
	parameter int unsigned BUSY_PHASES = lcdcd_pkg::BUSY_PHASES_DEF
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         reset_i,
	// host port
	input  wire logic         chip_select_a_i,
	input  wire logic         chip_select_b_i,
	input  wire logic         chip_select_c_i,
	input  wire logic         strobe_i,
	input  wire logic         read_not_write_i,
	input  wire logic         data_not_instr_i,
	input  wire logic [7:0]   host_data_bus_i,
	output logic      [7:0]   host_data_bus_o,
	output logic              host_data_bus_oe_o,
	// internal two-phase clock pins
	input  wire logic         phase_a_clock_i,
	input  wire logic         phase_b_clock_i,
	// row driver timing and strap
	input  wire logic         frame_sync_i,
	input  wire logic         line_latch_clock_i,
	input  wire logic         ac_polarity_i,
	input  wire logic         addr_dir_select_i,
	// segment outputs, two-bit level code per segment
	output logic      [127:0] segment_outputs_o
);
	import lcdcd_pkg::*;

	// ************************************************************
	// parameter check
	// ************************************************************
	if (BUSY_PHASES < 1 || BUSY_PHASES > 3) begin : g_bad_busy
		$error("BUSY_PHASES must lie between 1 and 3");
	end

	localparam logic [1:0] BUSY_LAST = 2'(BUSY_PHASES - 1);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic       display_onoff_state;
		logic [5:0] scroll_start_line;
		logic [2:0] page_address;
		logic [5:0] column_address_counter;
		logic [5:0] line_counter;
		logic [7:0] input_reg;
		logic [7:0] output_reg;
		logic [7:0] bus_out;
		lcdcd_op_t  op;
		lcdcd_fsm_t fsm;
		logic [1:0] phase_cnt;
		logic       reset_flag;
		logic       strobe_q;
		logic       latch_q;
		logic       pha_q;
		logic       phb_q;
		logic [63:0] row;
	} lcdcd_core_st_t;

	lcdcd_core_st_t st_reg;
	lcdcd_core_st_t st_next;

	logic [7:0] ram_mem [RAM_WORDS];

	function automatic lcdcd_ins_t classify(input logic [7:0] b);
		if ((b & INS_ONOFF_MASK) == INS_ONOFF_CODE) begin
			return INS_ONOFF;
		end else if ((b & INS_PAGE_MASK) == INS_PAGE_CODE) begin
			return INS_PAGE;
		end else if ((b & INS_START_MASK) == INS_START_CODE) begin
			return INS_START;
		end else if ((b & INS_YADDR_MASK) == INS_YADDR_CODE) begin
			return INS_YADDR;
		end
		return INS_NONE;
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [SYNC_WIDTH-1:0] pins_s;
	logic       cs_a_s;
	logic       cs_b_s;
	logic       cs_c_s;
	logic       strobe_s;
	logic       rw_s;
	logic       di_s;
	logic       frame_s;
	logic       latch_s;
	logic       pol_s;
	logic       pha_s;
	logic       phb_s;
	logic       adc_s;
	logic [7:0] bus_s;

	lcdcd_sync #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.raw_i   ({chip_select_a_i, chip_select_b_i, chip_select_c_i, strobe_i,
			read_not_write_i, data_not_instr_i, frame_sync_i, line_latch_clock_i,
			ac_polarity_i, phase_a_clock_i, phase_b_clock_i, addr_dir_select_i,
			host_data_bus_i}),
		.sync_o  (pins_s)
	);

	assign {cs_a_s, cs_b_s, cs_c_s, strobe_s, rw_s, di_s, frame_s, latch_s,
		pol_s, pha_s, phb_s, adc_s, bus_s} = pins_s;

	// ************************************************************
	// decode and edges
	// ************************************************************
	logic       selected;
	logic       strobe_fall;
	logic       latch_rise;
	logic       pha_rise;
	logic       phb_rise;
	logic       busy;
	logic       accept;
	logic       ram_we;
	logic [8:0] ram_addr;
	logic [7:0] status_byte;
	lcdcd_ins_t exec_ins;

	assign selected    = !cs_a_s && !cs_b_s && cs_c_s;
	assign strobe_fall = st_reg.strobe_q && !strobe_s;
	assign latch_rise  = !st_reg.latch_q && latch_s;
	assign pha_rise    = !st_reg.pha_q && pha_s;
	assign phb_rise    = !st_reg.phb_q && phb_s;
	assign busy        = (st_reg.fsm != ST_IDLE);
	// page on top, column counter below
	assign ram_addr    = {st_reg.page_address, st_reg.column_address_counter};
	assign exec_ins    = classify(st_reg.input_reg);
	// status reads are always served; anything else waits for idle
	assign accept      = selected && strobe_fall && !busy && !st_reg.reset_flag
		&& !(rw_s && !di_s);
	assign ram_we      = (st_reg.fsm == ST_EXEC) && pha_rise && (st_reg.op == OP_WDATA);

	always_comb begin
		status_byte                 = 8'h00;
		status_byte[STAT_BUSY_BIT]  = busy;
		status_byte[STAT_OFF_BIT]   = !st_reg.display_onoff_state;
		status_byte[STAT_RESET_BIT] = st_reg.reset_flag;
	end

	// ************************************************************
	// row fetch for the scan side
	// ************************************************************
	// direction select is read live, which is why it must be strapped
	logic [63:0] row_fetch;
	for (genvar k = 0; k < SEG_COUNT; k++) begin : g_row
		logic [5:0] col;
		assign col = adc_s ? 6'(k) : 6'(63 - k);
		assign row_fetch[k] = ram_mem[{st_reg.line_counter[5:3], col}][st_reg.line_counter[2:0]];
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next            = st_reg;
		st_next.strobe_q   = strobe_s;
		st_next.latch_q    = latch_s;
		st_next.pha_q      = pha_s;
		st_next.phb_q      = phb_s;
		st_next.reset_flag = 1'b0;

		// read data path: present output register, status otherwise
		if (selected && rw_s) begin
			st_next.bus_out = di_s ? st_reg.output_reg : status_byte;
		end

		// host accesses at the strobe fall
		if (accept) begin
			case ({di_s, rw_s})
				2'b11: begin
					// reload follows the read; stale data served first
					st_next.output_reg = ram_mem[ram_addr];
					st_next.column_address_counter = st_reg.column_address_counter
						+ 6'h01;
					st_next.op  = OP_NONE;
					st_next.fsm = ST_HOLD;
					st_next.phase_cnt = 2'h0;
				end
				2'b10: begin
					st_next.input_reg = bus_s;
					st_next.op  = OP_WDATA;
					st_next.fsm = ST_EXEC;
				end
				2'b00: begin
					st_next.input_reg = bus_s;
					st_next.op  = OP_INSTR;
					st_next.fsm = ST_EXEC;
				end
				default: begin
					st_next.op = OP_NONE;
				end
			endcase
		end

		// execution paced by the phase clocks
		case (st_reg.fsm)
			ST_IDLE: begin
				st_next.phase_cnt = 2'h0;
			end
			ST_EXEC: begin
				if (pha_rise) begin
					st_next.fsm       = ST_HOLD;
					st_next.phase_cnt = 2'h0;
					if (st_reg.op == OP_WDATA) begin
						st_next.column_address_counter = st_reg.column_address_counter
							+ 6'h01;
					end else if (st_reg.op == OP_INSTR) begin
						// only these decodes touch on/off and start line
						case (exec_ins)
							INS_ONOFF: st_next.display_onoff_state = st_reg.input_reg[0];
							INS_START: st_next.scroll_start_line = st_reg.input_reg[5:0];
							INS_PAGE:  st_next.page_address = st_reg.input_reg[2:0];
							INS_YADDR: st_next.column_address_counter = st_reg.input_reg[5:0];
							default:   st_next.op = OP_NONE;
						endcase
					end
				end
			end
			ST_HOLD: begin
				// busy drops after a fixed count of phase periods
				if (phb_rise) begin
					st_next.phase_cnt = st_reg.phase_cnt + 2'h1;
					if (st_reg.phase_cnt == BUSY_LAST) begin
						st_next.fsm = ST_IDLE;
						st_next.op  = OP_NONE;
					end
				end
			end
			default: begin
				st_next.fsm = ST_IDLE;
			end
		endcase

		// scan side: row latch on rise, frame sync presets the line counter
		if (latch_rise) begin
			st_next.row          = row_fetch;
			st_next.line_counter = st_reg.line_counter + 6'h01;
		end
		if (frame_s) begin
			st_next.line_counter = st_reg.scroll_start_line;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	// reset acts without the chip selects
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_reg                        <= '0;
			st_reg.display_onoff_state    <= ONOFF_RST;
			st_reg.scroll_start_line      <= START_RST;
			st_reg.page_address           <= PAGE_RST;
			st_reg.column_address_counter <= YADDR_RST;
			st_reg.op                     <= OP_NONE;
			st_reg.fsm                    <= ST_IDLE;
			st_reg.reset_flag             <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ram write is the internal copy from the input register
	always_ff @(posedge mclk_i) begin
		if (ram_we) begin
			ram_mem[ram_addr] <= st_reg.input_reg;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// enable is combinational from synced pins; data comes from a flop
	assign host_data_bus_oe_o = selected && rw_s && strobe_s;
	assign host_data_bus_o    = st_reg.bus_out;

	lcdcd_segdrv u_segdrv (
		.mclk_i          (mclk_i),
		.reset_i         (reset_i),
		.row_i           (st_reg.row),
		.display_on_i    (st_reg.display_onoff_state),
		.ac_polarity_i   (pol_s),
		.segment_level_o (segment_outputs_o)
	);

	// ************************************************************
	// checks
	// ************************************************************
	sequence seq_read_at_top;
		accept && di_s && rw_s && st_reg.column_address_counter == YADDR_LAST;
	endsequence

	sequence seq_wrapped;
		st_reg.column_address_counter == YADDR_RST && st_reg.fsm == ST_HOLD;
	endsequence

	AST_Y_WRAP: assert property (@(posedge mclk_i) disable iff (reset_i)
		seq_read_at_top |=> seq_wrapped)
		else $error("column counter did not wrap to zero");

	AST_NO_DRIVE_DESELECTED: assert property (@(posedge mclk_i) disable iff (reset_i)
		!selected |-> !host_data_bus_oe_o)
		else $error("bus driven while deselected");

	AST_RESET_VALUES: assert property (@(posedge mclk_i) disable iff (reset_i)
		st_reg.reset_flag |-> !st_reg.display_onoff_state && st_reg.scroll_start_line == 6'h00)
		else $error("reset values wrong after release");

	AST_BUSY_BIT: assert property (@(posedge mclk_i) disable iff (reset_i)
		selected && rw_s && !di_s && $past(selected && rw_s && !di_s)
		|-> host_data_bus_o[STAT_BUSY_BIT] == $past(busy))
		else $error("busy not shown on bit seven");

	AST_OFF_BIT: assert property (@(posedge mclk_i) disable iff (reset_i)
		$past(selected && rw_s && !di_s)
		|-> host_data_bus_o[STAT_OFF_BIT] == !$past(st_reg.display_onoff_state))
		else $error("display state not shown on bit five");

	AST_ACCEPT_BUSY: assert property (@(posedge mclk_i) disable iff (reset_i)
		accept |=> busy ##1 busy)
		else $error("busy not raised after an accepted access");

	AST_FRAME_PRESET: assert property (@(posedge mclk_i) disable iff (reset_i)
		frame_s |=> st_reg.line_counter == $past(st_reg.scroll_start_line))
		else $error("line counter not preset by frame sync");

	// case equality on the row: columns never written hold unknown bits
	AST_LINE_ADVANCE: assert property (@(posedge mclk_i) disable iff (reset_i)
		latch_rise && !frame_s |=> st_reg.line_counter == $past(st_reg.line_counter) + 6'h01
		&& st_reg.row === $past(row_fetch))
		else $error("row latch or line advance missed");

	AST_PAGE_STABLE: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(st_reg.fsm == ST_EXEC && st_reg.op == OP_INSTR && exec_ins == INS_PAGE)
		|=> $stable(st_reg.page_address))
		else $error("page changed without a page instruction");

	AST_ONOFF_ONLY_BY_INSTR: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(st_reg.fsm == ST_EXEC && pha_rise && exec_ins == INS_ONOFF)
		|=> $stable(st_reg.display_onoff_state))
		else $error("on/off state changed without instruction");

endmodule

// file: logic/lcdcd_pkg.sv
package lcdcd_pkg;

	// ************************************************************
	// host port decode
	// ************************************************************
	localparam logic [7:0] INS_ONOFF_CODE = 8'h3E;
	localparam logic [7:0] INS_ONOFF_MASK = 8'hFE;
	localparam logic [7:0] INS_START_CODE = 8'hC0;
	localparam logic [7:0] INS_START_MASK = 8'hC0;
	localparam logic [7:0] INS_PAGE_CODE  = 8'hB8;
	localparam logic [7:0] INS_PAGE_MASK  = 8'hF8;
	localparam logic [7:0] INS_YADDR_CODE = 8'h40;
	localparam logic [7:0] INS_YADDR_MASK = 8'hC0;

	// status byte bit positions
	localparam int STAT_BUSY_BIT  = 7;
	localparam int STAT_OFF_BIT   = 5;
	localparam int STAT_RESET_BIT = 4;

	// ************************************************************
	// reset values and sizes
	// ************************************************************
	localparam logic       ONOFF_RST   = 1'h0;
	localparam logic [5:0] START_RST   = 6'h00;
	localparam logic [2:0] PAGE_RST    = 3'h0;
	localparam logic [5:0] YADDR_RST   = 6'h00;
	localparam logic [5:0] YADDR_LAST  = 6'h3F;
	localparam int         SEG_COUNT   = 64;
	localparam int         RAM_WORDS   = 512;
	localparam int         SYNC_WIDTH  = 20;
	// busy lasts this many second-phase clock periods after execution
	localparam int unsigned BUSY_PHASES_DEF = 2;

	// segment drive level codes
	localparam logic [1:0] LEVEL_A = 2'h0;
	localparam logic [1:0] LEVEL_B = 2'h1;
	localparam logic [1:0] LEVEL_C = 2'h2;
	localparam logic [1:0] LEVEL_D = 2'h3;

	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_HOLD = 3'b100
	} lcdcd_fsm_t;

	typedef enum logic [1:0] {
		OP_NONE  = 2'h0,
		OP_WDATA = 2'h1,
		OP_INSTR = 2'h2
	} lcdcd_op_t;

	typedef enum logic [2:0] {
		INS_NONE  = 3'h0,
		INS_ONOFF = 3'h1,
		INS_START = 3'h2,
		INS_PAGE  = 3'h3,
		INS_YADDR = 3'h4
	} lcdcd_ins_t;

endpackage

// file: logic/lcdcd_sync.sv
`timescale 1ns/1ps
module lcdcd_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// raw pins and filtered result
	input  wire logic [WIDTH-1:0] raw_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} lcdcd_sync_st_t;

	lcdcd_sync_st_t st_reg;
	lcdcd_sync_st_t st_next;

	// a bit moves only once stages two and three agree; s1 feeds s2 only
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = raw_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.q;

endmodule

// file: logic/lcdcd_segdrv.sv
`timescale 1ns/1ps
module lcdcd_segdrv (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         reset_i,
	// latched row, display state, polarity
	input  wire logic [63:0]  row_i,
	input  wire logic         display_on_i,
	input  wire logic         ac_polarity_i,
	// two-bit level code per segment
	output logic      [127:0] segment_level_o
);
	import lcdcd_pkg::*;

	typedef struct packed {
		logic [127:0] level;
	} lcdcd_seg_st_t;

	lcdcd_seg_st_t st_reg;
	lcdcd_seg_st_t st_next;

	// off state forces the dark level, ram is never touched
	always_comb begin
		logic lit;
		lit     = 1'b0;
		st_next = st_reg;
		for (int k = 0; k < SEG_COUNT; k++) begin
			lit = row_i[k] & display_on_i;
			if (ac_polarity_i) begin
				st_next.level[2*k +: 2] = lit ? LEVEL_A : LEVEL_C;
			end else begin
				st_next.level[2*k +: 2] = lit ? LEVEL_B : LEVEL_D;
			end
		end
	end

	// reset shows the off level for the reset polarity, so no false lit code appears
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			st_reg.level <= {SEG_COUNT{LEVEL_D}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign segment_level_o = st_reg.level;

	AST_SEG_LEVEL: assert property (@(posedge mclk_i) disable iff (reset_i)
		segment_level_o[1:0] == (!$past(display_on_i) || !$past(row_i[0]) ?
			($past(ac_polarity_i) ? LEVEL_C : LEVEL_D) :
			($past(ac_polarity_i) ? LEVEL_A : LEVEL_B)))
		else $error("segment one level does not match data and polarity");

endmodule

// file: dv/lcdcd_row_model.sv
`timescale 1ns/1ps
// ************************************************************
// row driver side: phase clocks, frame, line latch, polarity
// ************************************************************
module lcdcd_row_model (
	// clock
	input  wire logic mclk_i,
	// timing toward the column driver
	output logic      phase_a_o,
	output logic      phase_b_o,
	output logic      frame_sync_o,
	output logic      line_latch_o,
	output logic      ac_polarity_o
);
	int unsigned cnt;

	initial begin
		cnt = 0;
		phase_a_o = 1'b0;
		phase_b_o = 1'b0;
		frame_sync_o = 1'b0;
		line_latch_o = 1'b0;
		ac_polarity_o = 1'b1;
	end

	// free-running phases, 8 mclk per level so the synchronisers never miss one
	always @(posedge mclk_i) begin
		cnt <= cnt + 1;
		phase_a_o <= #1 ((cnt % 16) < 8);
		phase_b_o <= #1 (((cnt + 4) % 16) < 8);
	end

	// frame start loads the start line, then one latch rise shows that line
	task automatic scan_first_line();
		@(posedge mclk_i);
		#1 frame_sync_o = 1'b1;
		repeat (8) @(posedge mclk_i);
		#1 frame_sync_o = 1'b0;
		repeat (8) @(posedge mclk_i);
		#1 line_latch_o = 1'b1;
		repeat (8) @(posedge mclk_i);
		#1 line_latch_o = 1'b0;
		repeat (8) @(posedge mclk_i);
		#1;
	endtask

	task automatic set_polarity(input logic p);
		@(posedge mclk_i);
		#1 ac_polarity_o = p;
		repeat (8) @(posedge mclk_i);
		#1;
	endtask
endmodule

// file: dv/test_lcd_column_driver_host_and_scan.sv
`timescale 1ns/1ps
// ************************************************************
// host port and scan bench
// ************************************************************
module test_lcd_column_driver_host_and_scan;
	import lcdcd_pkg::*;
	logic         mclk, reset, cs_a, cs_b, cs_c, strobe, rnw, dni;
	logic [7:0]   bus_in, bus_out;
	logic         bus_oe, ph_a, ph_b, frame, latch, pol, adc;
	logic [127:0] seg;
	logic [7:0]   s;
	int           errors = 0;
	int           n_compared = 0;

	lcdcd_core lcdcd_core_i (
		.mclk_i             (mclk),
		.reset_i            (reset),
		.chip_select_a_i    (cs_a),
		.chip_select_b_i    (cs_b),
		.chip_select_c_i    (cs_c),
		.strobe_i           (strobe),
		.read_not_write_i   (rnw),
		.data_not_instr_i   (dni),
		.host_data_bus_i    (bus_in),
		.host_data_bus_o    (bus_out),
		.host_data_bus_oe_o (bus_oe),
		.phase_a_clock_i    (ph_a),
		.phase_b_clock_i    (ph_b),
		.frame_sync_i       (frame),
		.line_latch_clock_i (latch),
		.ac_polarity_i      (pol),
		.addr_dir_select_i  (adc),
		.segment_outputs_o  (seg)
	);

	lcdcd_row_model lcdcd_row_model_i (
		.mclk_i        (mclk),
		.phase_a_o     (ph_a),
		.phase_b_o     (ph_b),
		.frame_sync_o  (frame),
		.line_latch_o  (latch),
		.ac_polarity_o (pol)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_level(input string n, input logic [1:0] e, input logic [1:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// one strobe cycle; selects idle between cycles, data held past the fall
	task automatic bus_cycle(input logic sel, di, rw, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge mclk);
		#1;
		cs_a = !sel;
		cs_b = !sel;
		cs_c = sel;
		dni = di;
		rnw = rw;
		bus_in = d;
		strobe = 1'b1;
		repeat (10) @(posedge mclk);
		#1 q = bus_out;
		chk_byte("bus_oe", {7'h00, sel & rw}, {7'h00, bus_oe});
		strobe = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		cs_a = 1'b1;
		cs_b = 1'b1;
		cs_c = 1'b0;
	endtask

	// poll status until neither busy nor reset shows, bounded
	task automatic wait_ready();
		logic [7:0] st;
		for (int i = 0; i < 40; i++) begin
			bus_cycle(1'b1, 1'b0, 1'b1, 8'h00, st);
			if (st[STAT_BUSY_BIT] === 1'b0 && st[STAT_RESET_BIT] === 1'b0) return;
		end
		errors++;
		$display("CHECK FAILED busy_wait expected 00 seen %h", st);
		end_sim();
	endtask

	task automatic acc(input logic di, rw, input logic [7:0] d, output logic [7:0] q);
		wait_ready();
		bus_cycle(1'b1, di, rw, d, q);
	endtask

	// watchdog: a hang counts as a mismatch
	initial begin
		#400000;
		errors++;
		end_sim();
	end

	initial begin
		reset = 1'b1;
		adc = 1'b1;
		{cs_a, cs_b, cs_c, strobe, rnw, dni, bus_in} = {3'b110, 3'b000, 8'h00};
		repeat (10) @(posedge mclk);
		#1 reset = 1'b0;
		acc(1'b0, 1'b1, 8'h00, s);
		chk_byte("status_rst", 8'h20, s);
		acc(1'b0, 1'b0, 8'h3F, s);
		acc(1'b0, 1'b1, 8'h00, s);
		chk_byte("status_on", 8'h00, s);
		acc(1'b0, 1'b0, 8'hB9, s);
		acc(1'b0, 1'b0, 8'h7F, s);
		acc(1'b1, 1'b0, 8'hA5, s);
		acc(1'b1, 1'b0, 8'h3C, s);
		acc(1'b0, 1'b0, 8'h40, s);
		wait_ready();
		bus_cycle(1'b0, 1'b1, 1'b0, 8'hFF, s);
		acc(1'b0, 1'b0, 8'h7F, s);
		acc(1'b1, 1'b1, 8'h00, s);
		acc(1'b1, 1'b1, 8'h00, s);
		chk_byte("rd_col63", 8'hA5, s);
		acc(1'b0, 1'b0, 8'h7F, s);
		acc(1'b1, 1'b1, 8'h00, s);
		chk_byte("rd_stale", 8'h3C, s);
		acc(1'b0, 1'b0, 8'hC8, s);
		wait_ready();
		lcdcd_row_model_i.scan_first_line();
		chk_level("seg1_p1", LEVEL_C, seg[1:0]);
		chk_level("seg64_p1", LEVEL_A, seg[127:126]);
		lcdcd_row_model_i.set_polarity(1'b0);
		chk_level("seg1_p0", LEVEL_D, seg[1:0]);
		chk_level("seg64_p0", LEVEL_B, seg[127:126]);
		acc(1'b0, 1'b0, 8'h3E, s);
		wait_ready();
		chk_level("seg64_off", LEVEL_D, seg[127:126]);
		acc(1'b0, 1'b0, 8'h3F, s);
		wait_ready();
		chk_level("seg64_on", LEVEL_B, seg[127:126]);
		// second reset mid-run; the strap moves only while reset holds the chip
		@(posedge mclk);
		#1 reset = 1'b1;
		adc = 1'b0;
		repeat (10) @(posedge mclk);
		#1 reset = 1'b0;
		acc(1'b0, 1'b0, 8'h00, s);
		acc(1'b0, 1'b1, 8'h00, s);
		chk_byte("status_rst2", 8'h20, s);
		// reversed strap: column 0 on segment 64, start line back at zero
		acc(1'b0, 1'b0, 8'h3F, s);
		acc(1'b0, 1'b0, 8'hB8, s);
		acc(1'b0, 1'b0, 8'h40, s);
		acc(1'b1, 1'b0, 8'h01, s);
		acc(1'b0, 1'b0, 8'h7F, s);
		acc(1'b1, 1'b0, 8'hFE, s);
		wait_ready();
		lcdcd_row_model_i.scan_first_line();
		chk_level("seg1_rev", LEVEL_D, seg[1:0]);
		chk_level("seg64_rev", LEVEL_B, seg[127:126]);
		end_sim();
	end
endmodule
